// File: rtl/bps_device.sv
// Cell-monitor end: protection state machine, registers and watchdog.
`timescale 1ns/1ps
`default_nettype none
`include "bps_map.svh"
module bps_device #(
    parameter int unsigned TICK_CYC = `BPS_TICK_CYC
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    bps_link_if.dev                 link,
    input  wire logic signed [15:0] cur_ma,
    input  wire logic               load_det,
    input  wire logic               chgr_det,
    input  wire logic               comm_fail,
    input  wire logic               supply_fail,
    input  wire logic               internal_fault,
    input  wire logic               ref_fault,
    input  wire logic [5:0]         prot_alarm,
    output var  logic               prot_fet_on,
    output var  logic               charge_fet_on,
    output var  logic               discharge_fet,
    output var  logic               sleep_discharge_fet,
    output var  logic               ow_check,
    output var  logic [7:0]         alarm_latch
);
    bps_pkg::bps_state_e st_q, st_d, tgt_q, tgt_d;
    bps_pkg::bps_word_t  delay_q, thr_q, quiet_q, wdog_q, ow_q;
    logic [7:0]  fen_q, rec_q, trig, nonrec, latch_set;
    logic        tick, wr_fire, rd_fire, cmd_fire, cmd_sleep, cmd_safe;
    logic        below, wdog_exp;

    function automatic logic is_active(input bps_pkg::bps_state_e s);
        return s == bps_pkg::charging_state || s == bps_pkg::discharging_state;
    endfunction

    function automatic logic [16:0] mag(input logic signed [15:0] v);
        logic signed [16:0] w;
        w = {v[15], v};
        return w[16] ? 17'(-w) : 17'(w);
    endfunction

    bps_tick #(.CYC(TICK_CYC)) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick_q  (tick)
    );

    assign wr_fire   = link.req && !link.ack && link.req_we;
    assign rd_fire   = link.req && !link.ack && !link.req_we;
    assign cmd_fire  = wr_fire && link.req_addr == `BPS_A_CMD;
    assign cmd_sleep = cmd_fire && link.req_wdata[1:0] == `BPS_CMD_SLEEP;
    assign cmd_safe  = cmd_fire && link.req_wdata[1:0] == `BPS_CMD_SAFE;
    assign below     = mag(cur_ma) < {1'b0, thr_q};

    // Faults are levels; bit 0 is the system error, bit 1 the sense error.
    assign trig = {prot_alarm,
                   ref_fault && fen_q[`BPS_FEN_SELF], // RL2
                   comm_fail || supply_fail || internal_fault}; // RL1
    assign nonrec = trig & ~rec_q;

    // Register writes and read answers over the link.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delay_q <= `BPS_RST_DELAY;
            thr_q   <= `BPS_RST_THR;
            fen_q   <= `BPS_RST_FEN;
            rec_q   <= `BPS_RST_REC;
        end else if (wr_fire) begin
            case (link.req_addr)
                `BPS_A_DELAY: delay_q <= link.req_wdata;
                `BPS_A_THR:   thr_q   <= link.req_wdata;
                `BPS_A_FEN:   fen_q   <= link.req_wdata[7:0];
                `BPS_A_REC:   rec_q   <= link.req_wdata[7:0];
                default:      ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.ack   <= 1'b0;
            link.rdata <= 16'h0000;
        end else begin
            link.ack <= link.req && !link.ack;
            if (rd_fire) begin
                case (link.req_addr)
                    `BPS_A_DELAY: link.rdata <= delay_q;
                    `BPS_A_THR:   link.rdata <= thr_q;
                    `BPS_A_FEN:   link.rdata <= {8'h00, fen_q};
                    `BPS_A_REC:   link.rdata <= {8'h00, rec_q};
                    `BPS_A_STAT:  link.rdata <= {alarm_latch, trig};
                    default:      link.rdata <= 16'h0000;
                endcase
            end
        end
    end

    always_comb begin
        st_d  = st_q;
        tgt_d = tgt_q;
        case (st_q)
            bps_pkg::discharge_wake:    st_d = bps_pkg::discharging_state; // RL3
            bps_pkg::charge_wake_state: st_d = bps_pkg::charging_state; // RL4
            bps_pkg::charging_state: begin
                if (cur_ma < -`BPS_HYST_MA) st_d = bps_pkg::discharging_state; // RL7
            end
            bps_pkg::discharging_state: begin
                if (cur_ma > `BPS_HYST_MA) st_d = bps_pkg::charging_state; // RL7
            end
            bps_pkg::low_power_state: begin
                if (fen_q[`BPS_FEN_PMOS] && cur_ma < -`BPS_HYST_MA) begin
                    st_d = bps_pkg::discharging_state; // RL9
                end
                if (cmd_safe) st_d = bps_pkg::safe_state;
            end
            bps_pkg::safe_state: begin
                if (cmd_safe) st_d = bps_pkg::discharge_wake; // RL16
            end
            bps_pkg::alarm_state: begin
                if ((cmd_sleep || cmd_safe) && trig == 8'h00) begin // RL12
                    st_d  = bps_pkg::alarm_reset_state;
                    tgt_d = cmd_sleep ? bps_pkg::low_power_state : bps_pkg::safe_state;
                end
            end
            bps_pkg::alarm_reset_state:  st_d = tgt_q; // RL17
            bps_pkg::auto_recover_state: begin
                if (trig == 8'h00) st_d = bps_pkg::discharge_wake; // RL18
            end
            default: st_d = bps_pkg::safe_state;
        endcase
        if (st_q == bps_pkg::safe_state || st_q == bps_pkg::low_power_state) begin
            if (chgr_det && fen_q[`BPS_FEN_CHGR]) st_d = bps_pkg::charge_wake_state; // RL15
            if (load_det && fen_q[`BPS_FEN_LOAD]) st_d = bps_pkg::discharge_wake; // RL14
        end
        if (is_active(st_q) || st_q == bps_pkg::discharge_wake
                || st_q == bps_pkg::charge_wake_state) begin
            if (is_active(st_q) && fen_q[`BPS_FEN_AUTO] && below
                    && quiet_q >= delay_q) begin
                st_d = bps_pkg::low_power_state; // RL21
            end
            if (cmd_sleep) st_d = bps_pkg::low_power_state;
            if (cmd_safe) st_d = bps_pkg::safe_state;
        end
        // Faults override every other move; an open alarm keeps its own exit.
        if (st_q != bps_pkg::alarm_state && trig != 8'h00) begin
            st_d = (nonrec != 8'h00) ? bps_pkg::alarm_state // RL10 RL19
                                     : bps_pkg::auto_recover_state; // RL18
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= bps_pkg::safe_state;
            tgt_q <= bps_pkg::safe_state;
            link.state <= bps_pkg::safe_state;
        end else begin
            st_q  <= st_d;
            tgt_q <= tgt_d;
            link.state <= st_d;
        end
    end

    // Latching happens only in the alarm state, so recoverable faults latch too.
    assign latch_set = (st_d == bps_pkg::alarm_state) ? trig : 8'h00; // RL19

    for (genvar i = 0; i < 8; i++) begin : g_latch
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                alarm_latch[i] <= 1'b0;
            end else begin
                alarm_latch[i] <= latch_set[i] ||
                    (alarm_latch[i] && st_q != bps_pkg::alarm_reset_state); // RL17
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prot_fet_on         <= 1'b0;
            charge_fet_on       <= 1'b0;
            discharge_fet       <= 1'b0;
            sleep_discharge_fet <= 1'b0;
        end else begin
            prot_fet_on   <= is_active(st_d) || st_d == bps_pkg::discharge_wake
                             || st_d == bps_pkg::charge_wake_state; // RL3 RL4 RL10 RL13
            charge_fet_on <= is_active(st_d); // RL5 RL6
            discharge_fet <= is_active(st_d); // RL5 RL6
            // The sleep FET opens only once the main FETs are seen closed.
            sleep_discharge_fet <= (st_d == bps_pkg::low_power_state
                                    && fen_q[`BPS_FEN_PMOS])
                || (sleep_discharge_fet && !(charge_fet_on && discharge_fet)); // RL9
        end
    end

    // Quiet-current timer for automatic standby, counted in ticks.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_q <= 16'h0000;
        end else if (!(is_active(st_q) && below)) begin
            quiet_q <= 16'h0000;
        end else if (tick && quiet_q != 16'hFFFF) begin
            quiet_q <= quiet_q + 16'h0001; // RL21
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ow_q     <= 16'h0000;
            ow_check <= 1'b0;
        end else begin
            ow_check <= 1'b0;
            if (!fen_q[`BPS_FEN_OW] || !(st_q == bps_pkg::alarm_state
                                         || st_q == bps_pkg::safe_state)) begin
                ow_q <= 16'h0000;
            end else if (tick) begin
                if (ow_q == `BPS_OW_TICKS - 16'h0001) begin
                    ow_q     <= 16'h0000;
                    ow_check <= 1'b1; // RL11
                end else begin
                    ow_q <= ow_q + 16'h0001;
                end
            end
        end
    end

    assign wdog_exp = tick && wdog_q == `BPS_WDOG_TICKS - 16'h0001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_q          <= 16'h0000;
            link.host_reset <= 1'b0;
            link.wake_host  <= 1'b0;
        end else begin
            if (wr_fire || wdog_exp) begin
                wdog_q <= 16'h0000; // RL22
            end else if (tick) begin
                wdog_q <= wdog_q + 16'h0001;
            end
            link.host_reset <= wdog_exp && !wr_fire && fen_q[`BPS_FEN_WDOG]; // RL20
            link.wake_host  <= st_q == bps_pkg::low_power_state
                && (st_d == bps_pkg::alarm_state
                    || st_d == bps_pkg::auto_recover_state); // RL8
        end
    end
endmodule
`default_nettype wire

// File: rtl/bps_map.svh
// Constants and register map of the battery protection state controller.
// Summary of operation
// RL1 - System error always armed: link, supply, internal faults.
// RL2 - Sense error counts only with self-test enabled.
// RL3 - Discharge wake closes protection FETs, then settles.
// RL4 - Charge wake closes protection FETs, then settles.
// RL5 - Charging state holds all FETs closed.
// RL6 - Discharging state holds all FETs closed.
// RL7 - Charge/discharge switching uses a current hysteresis band.
// RL8 - Standby: host gates gauge, sleeps; alarm wakes it.
// RL9 - Standby PMOS kept; discharge exits, sleep FET last.
// RL10 - Enabled alarm opens protection FETs, enters alarm.
// RL11 - Alarm or safe: open-wire check every 10 s.
// RL12 - Alarm exits only by command with alarms clear.
// RL13 - Safe state: FETs open, no alarm, measuring.
// RL14 - Load detection enabled: load moves to discharge wake.
// RL15 - Charger detection enabled: charger moves to charge wake.
// RL16 - Detection off: only safe command restores activity.
// RL17 - Alarm-reset state clears every alarm latch.
// RL18 - All faults recoverable: auto-recovery, nothing latched.
// RL19 - Any unrecoverable fault: alarm, latch all active faults.
// RL20 - Watchdog expires after 1 s; may reset host.
// RL21 - Auto-standby after low current for configured delay.
// RL22 - Every host write restarts the watchdog interval.
`ifndef BPS_MAP_SVH
`define BPS_MAP_SVH

`define BPS_CLK_MHZ       200
`define BPS_TICK_US       1000
`define BPS_TICK_CYC      (`BPS_TICK_US * `BPS_CLK_MHZ)
`define BPS_TICKS_PER_S   1000
`define BPS_WDOG_S        1
`define BPS_OW_S          10
`define BPS_WDOG_TICKS    (16'(`BPS_WDOG_S * `BPS_TICKS_PER_S))
`define BPS_OW_TICKS      (16'(`BPS_OW_S * `BPS_TICKS_PER_S))

`define BPS_A_DELAY       16'h7FBD
`define BPS_A_THR         16'h7FBF
`define BPS_A_REC         16'h7FC2
`define BPS_A_FEN         16'h7FC4
`define BPS_A_CMD         16'h7FC6
`define BPS_A_STAT        16'h7FC8

`define BPS_FEN_OW        0
`define BPS_FEN_LOAD      1
`define BPS_FEN_CHGR      2
`define BPS_FEN_AUTO      3
`define BPS_FEN_PMOS      4
`define BPS_FEN_WDOG      5
`define BPS_FEN_SELF      6

`define BPS_RST_DELAY     16'h03E8
`define BPS_RST_THR       16'h000A
`define BPS_RST_FEN       8'h06
`define BPS_RST_REC       8'h00

`define BPS_CMD_SLEEP     2'h1
`define BPS_CMD_SAFE      2'h2
`define BPS_HYST_MA       16'sh0032

`define BPS_P_ADDR        12'h000
`define BPS_P_DATA        12'h004
`define BPS_P_GO          12'h008
`define BPS_P_RDATA       12'h00C
`define BPS_P_STAT        12'h010
`define BPS_GO_WR         0
`define BPS_GO_RD         1
`define BPS_STAT_RST      11

`endif

// File: rtl/bps_pkg.sv
// Types shared by both ends of the battery protection link.
`default_nettype none
package bps_pkg;
    typedef enum logic [8:0] {
        charge_wake_state   = 9'h001,
        discharge_wake      = 9'h002,
        charging_state      = 9'h004,
        discharging_state   = 9'h008,
        low_power_state     = 9'h010,
        alarm_state         = 9'h020,
        safe_state          = 9'h040,
        alarm_reset_state   = 9'h080,
        auto_recover_state  = 9'h100
    } bps_state_e;
    typedef logic [15:0] bps_word_t;
endpackage
`default_nettype wire

// File: rtl/bps_link_if.sv
// Link between the host controller and the cell-monitor controller.
`timescale 1ns/1ps
`default_nettype none
interface bps_link_if;
    logic                  req;
    logic                  req_we;
    bps_pkg::bps_word_t    req_addr;
    bps_pkg::bps_word_t    req_wdata;
    logic                  ack;
    bps_pkg::bps_word_t    rdata;
    bps_pkg::bps_state_e   state;
    logic                  wake_host;
    logic                  host_reset;

    modport dev (input req, req_we, req_addr, req_wdata,
                 output ack, rdata, state, wake_host, host_reset);
    modport host (output req, req_we, req_addr, req_wdata,
                  input ack, rdata, state, wake_host, host_reset);
endinterface
`default_nettype wire

// File: rtl/bps_tick.sv
// Divider that gives a one-cycle enable pulse every CYC clocks.
`timescale 1ns/1ps
`default_nettype none
module bps_tick #(
    parameter int unsigned CYC = 1000
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output var  logic tick_q
);
    logic [31:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else if (cnt_q == 32'(CYC - 1)) begin
            cnt_q  <= 32'h0000_0000;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 32'h0000_0001;
            tick_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: rtl/bps_host.sv
// Host end: APB register block that drives the link to the cell monitor.
`timescale 1ns/1ps
`default_nettype none
`include "bps_map.svh"
module bps_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    bps_link_if.host         link,
    output var  logic        gauge_en,
    output var  logic        mcu_sleep
);
    bps_pkg::bps_word_t rdata_q;
    logic        rst_seen_q, acc, wr, low;
    logic [2:0]  sel;

    function automatic logic [2:0] map(input logic [11:0] a);
        case (a)
            `BPS_P_ADDR:  return 3'h0;
            `BPS_P_DATA:  return 3'h1;
            `BPS_P_GO:    return 3'h2;
            `BPS_P_RDATA: return 3'h3;
            `BPS_P_STAT:  return 3'h4;
            default:      return 3'h7;
        endcase
    endfunction

    // One wait state: pready rises in the second access cycle.
    assign acc = psel && penable && !pready;
    assign wr  = psel && penable && pready && pwrite;
    assign sel = map(paddr);
    assign low = link.state == bps_pkg::low_power_state;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc;
            pslverr <= acc && sel == 3'h7;
            if (acc && !pwrite) begin
                case (sel)
                    3'h0:    prdata <= {16'h0000, link.req_addr};
                    3'h1:    prdata <= {16'h0000, link.req_wdata};
                    3'h2:    prdata <= {31'h0000_0000, link.req};
                    3'h3:    prdata <= {16'h0000, rdata_q};
                    3'h4:    prdata <= {20'h0_0000, rst_seen_q, mcu_sleep, gauge_en,
                                        link.state};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // A monitor-forced reset drops any transfer in flight.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.req       <= 1'b0;
            link.req_we    <= 1'b0;
            link.req_addr  <= 16'h0000;
            link.req_wdata <= 16'h0000;
            rdata_q        <= 16'h0000;
        end else if (link.host_reset) begin
            link.req <= 1'b0; // RL20
        end else if (link.req) begin
            if (link.ack) begin
                link.req <= 1'b0;
                if (!link.req_we) rdata_q <= link.rdata;
            end
        end else if (wr) begin
            case (sel)
                3'h0: link.req_addr  <= pwdata[15:0];
                3'h1: link.req_wdata <= pwdata[15:0];
                3'h2: begin
                    link.req    <= pwdata[`BPS_GO_WR] || pwdata[`BPS_GO_RD]; // RL12 RL16
                    link.req_we <= pwdata[`BPS_GO_WR];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_seen_q <= 1'b0;
        end else begin
            rst_seen_q <= link.host_reset || (rst_seen_q && !(wr && sel == 3'h4
                                                             && pwdata[`BPS_STAT_RST]));
        end
    end

    // Gauge is switched off one cycle before the host goes to sleep.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gauge_en  <= 1'b1;
            mcu_sleep <= 1'b0;
        end else if (link.wake_host || link.host_reset || !low) begin
            gauge_en  <= 1'b1; // RL8
            mcu_sleep <= 1'b0;
        end else if (gauge_en) begin
            gauge_en <= 1'b0; // RL8
        end else begin
            mcu_sleep <= 1'b1; // RL8
        end
    end
endmodule
`default_nettype wire

// File: tb/bps_sva.sv
// Link protocol and state sequencing checks for the protection pair.
`timescale 1ns/1ps
`default_nettype none
`include "bps_map.svh"
module bps_sva #(
    parameter int unsigned TICK_CYC = 10
) (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                req,
    input wire logic                req_we,
    input wire bps_pkg::bps_word_t  req_addr,
    input wire bps_pkg::bps_word_t  req_wdata,
    input wire logic                ack,
    input wire bps_pkg::bps_word_t  rdata,
    input wire bps_pkg::bps_state_e state,
    input wire logic                wake_host,
    input wire logic                host_reset
);
    logic [3:0]  cmd_age_q;
    int unsigned quiet_q;
    wire logic   cmd_take = ack && req_we && req_addr == `BPS_A_CMD;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_age_q <= 4'hF;
        end else if (cmd_take) begin
            cmd_age_q <= 4'h0;
        end else if (cmd_age_q != 4'hF) begin
            cmd_age_q <= cmd_age_q + 4'h1;
        end
    end

    // Counts silent cycles since the last write was answered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_q <= 0;
        end else if (ack && req_we) begin
            quiet_q <= 0;
        end else begin
            quiet_q <= quiet_q + 1;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_take;
        req && !ack;
    endsequence
    sequence s_answer;
        ack ##1 !ack;
    endsequence

    a_ack_next: assert property (s_take |=> s_answer)
        else $error("link request not answered in one cycle");
    a_ack_cause: assert property ($rose(ack) |-> $past(req))
        else $error("link answer without a request");
    a_rdata_hold: assert property ($changed(rdata) |-> ack)
        else $error("read data moved without an answer");
    a_alarm_exit: assert property (
        state != bps_pkg::alarm_state && $past(state) == bps_pkg::alarm_state
        |-> cmd_take || cmd_age_q < 4'h4)
        else $error("alarm state left without a command");
    a_charge_wake_brief: assert property (
        state == bps_pkg::charge_wake_state |-> ##[1:200] state != bps_pkg::charge_wake_state)
        else $error("charge wake state does not settle");
    a_reset_brief: assert property (
        state == bps_pkg::alarm_reset_state |-> ##[1:200] state != bps_pkg::alarm_reset_state)
        else $error("alarm reset state does not settle");
    a_host_rst_pulse: assert property (host_reset |=> !host_reset)
        else $error("host reset longer than one cycle");
    a_wake_host_cause: assert property (
        wake_host |-> state == bps_pkg::low_power_state || $past(state) == bps_pkg::low_power_state)
        else $error("host woken outside standby");
    a_wdog_quiet: assert property (host_reset |-> quiet_q >= 999 * TICK_CYC)
        else $error("host reset before a full silent interval");
endmodule
`default_nettype wire

// File: tb/bps_tb_top.sv
// Bench joining the host and device ends of the protection link.
`timescale 1ns/1ps
`default_nettype none
`include "bps_map.svh"
module bps_tb_top;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic               gauge_en, mcu_sleep, err, load_det, chgr_det, comm_fail;
    logic               supply_fail, internal_fault, ref_fault, prot_fet_on, charge_fet_on;
    logic               discharge_fet, sleep_discharge_fet, ow_check;
    logic signed [15:0] cur_ma;
    logic [5:0]         prot_alarm;
    logic [7:0]         alarm_latch;
    logic               rst_seen = 1'b0;
    int                 mismatches, compares;

    bps_link_if lnk();
    bps_device #(.TICK_CYC(10)) bps_device_i (.pclk(pclk), .presetn(presetn), .link(lnk),
        .cur_ma(cur_ma), .load_det(load_det), .chgr_det(chgr_det), .comm_fail(comm_fail),
        .supply_fail(supply_fail), .internal_fault(internal_fault), .ref_fault(ref_fault),
        .prot_alarm(prot_alarm), .prot_fet_on(prot_fet_on), .charge_fet_on(charge_fet_on),
        .discharge_fet(discharge_fet), .sleep_discharge_fet(sleep_discharge_fet),
        .ow_check(ow_check), .alarm_latch(alarm_latch));
    bps_host bps_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(lnk), .gauge_en(gauge_en), .mcu_sleep(mcu_sleep));
    bps_sva #(.TICK_CYC(10)) bps_sva_i (.pclk(pclk), .presetn(presetn), .req(lnk.req),
        .req_we(lnk.req_we), .req_addr(lnk.req_addr), .req_wdata(lnk.req_wdata),
        .ack(lnk.ack), .rdata(lnk.rdata), .state(lnk.state), .wake_host(lnk.wake_host),
        .host_reset(lnk.host_reset));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (lnk.host_reset === 1'b1) rst_seen <= 1'b1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Op 1 writes, op 2 reads; rd ends with the link read data.
    task automatic go(input logic [15:0] a, input logic [15:0] d, input logic [31:0] op);
        apb(1'b1, `BPS_P_ADDR, {16'h0000, a});
        apb(1'b1, `BPS_P_DATA, {16'h0000, d});
        apb(1'b1, `BPS_P_GO, op);
        do apb(1'b0, `BPS_P_GO, 32'h0000_0000); while (rd[0] !== 1'b0);
        apb(1'b0, `BPS_P_RDATA, 32'h0000_0000);
    endtask
    task automatic wst(input bps_pkg::bps_state_e s);
        while (lnk.state !== s) @(posedge pclk);
        chk(32'(lnk.state), 32'(s));
    endtask

    task automatic t_reset();
        apb(1'b0, `BPS_P_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_0240);
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        go(`BPS_A_DELAY, 16'h0000, 32'h0000_0002);
        chk(rd, 32'h0000_03E8);
    endtask
    task automatic t_active();
        cur_ma <= 16'sh01F4;
        chgr_det <= 1'b1;
        wst(bps_pkg::charge_wake_state);
        wst(bps_pkg::charging_state);
        repeat (2) @(posedge pclk);
        chk({29'h0, prot_fet_on, charge_fet_on, discharge_fet}, 32'h0000_0007);
        cur_ma <= -16'sh0014;
        repeat (20) @(posedge pclk);
        chk(32'(lnk.state), 32'(bps_pkg::charging_state));
        cur_ma <= -16'sh01F4;
        wst(bps_pkg::discharging_state);
        repeat (2) @(posedge pclk);
        chk({29'h0, prot_fet_on, charge_fet_on, discharge_fet}, 32'h0000_0007);
    endtask
    task automatic t_sleep();
        chgr_det <= 1'b0;
        go(`BPS_A_DELAY, 16'h0005, 32'h0000_0001);
        go(`BPS_A_FEN, 16'h000E, 32'h0000_0001);
        cur_ma <= 16'sh0000;
        repeat (30) @(posedge pclk);
        chk(32'(lnk.state), 32'(bps_pkg::discharging_state));
        wst(bps_pkg::low_power_state);
        repeat (3) @(posedge pclk);
        chk({30'h0, gauge_en, mcu_sleep}, 32'h0000_0001);
        prot_alarm <= 6'h01;
        wst(bps_pkg::alarm_state);
        repeat (3) @(posedge pclk);
        chk({29'h0, prot_fet_on, gauge_en, mcu_sleep}, 32'h0000_0002);
        chk(32'(alarm_latch), 32'h0000_0004);
    endtask
    task automatic t_alarm();
        go(`BPS_A_FEN, 16'h0006, 32'h0000_0001);
        go(`BPS_A_CMD, 16'h0002, 32'h0000_0001);
        repeat (5) @(posedge pclk);
        chk(32'(lnk.state), 32'(bps_pkg::alarm_state));
        prot_alarm <= 6'h00;
        go(`BPS_A_CMD, 16'h0002, 32'h0000_0001);
        wst(bps_pkg::safe_state);
        chk(32'(alarm_latch), 32'h0000_0000);
    endtask
    task automatic t_recover();
        go(`BPS_A_REC, 16'h0008, 32'h0000_0001);
        prot_alarm <= 6'h02;
        wst(bps_pkg::auto_recover_state);
        chk(32'(alarm_latch), 32'h0000_0000);
        prot_alarm <= 6'h00;
        wst(bps_pkg::discharge_wake);
    endtask
    task automatic t_wdog();
        go(`BPS_A_FEN, 16'h0026, 32'h0000_0001);
        repeat (9900) @(posedge pclk);
        chk({31'h0, rst_seen}, 32'h0000_0000);
        repeat (300) @(posedge pclk);
        chk({31'h0, rst_seen}, 32'h0000_0001);
        apb(1'b0, `BPS_P_STAT, 32'h0000_0000);
        chk({31'h0, rd[11]}, 32'h0000_0001);
    endtask

    task automatic finish_test();
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = 47'h0;
        cur_ma = 16'sh0000;
        {load_det, chgr_det, comm_fail, supply_fail, internal_fault, ref_fault} = 6'h00;
        prot_alarm = 6'h00;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_active();
        t_sleep();
        t_alarm();
        t_recover();
        t_wdog();
        finish_test();
    end
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end
endmodule
`default_nettype wire
